//--- verilog/sld_pkg.sv
/*
 * Package of the segment LCD frame, duty and display memory block:
 * register indices, field positions, reset values, duty codes, counts.
 * Assumes a 32-bit AXI4-Lite bus with one aligned word per register index.
 */
package sld_pkg;
    // Bus widths; word index is the byte address divided by four
    localparam int SLD_AW = 20;
    localparam int SLD_IW = 18;

    // Register indices (byte address is four times the index)
    localparam logic [17:0] IDX_CTRL      = 18'h050a2;
    localparam logic [17:0] IDX_IMSK      = 18'h050a5;
    localparam logic [17:0] IDX_IFLG      = 18'h050a6;
    localparam logic [17:0] IDX_PFSEL     = 18'h050a7;
    localparam logic [17:0] IDX_DMEM_BASE = 18'h053c0;
    localparam logic [17:0] IDX_DMEM_LAST = 18'h053df;

    // Drive control register fields and reset values
    localparam int         DUTY_LSB  = 0;
    localparam int         FDIV_LSB  = 4;
    localparam logic [2:0] DUTY_RST  = 3'h3;
    localparam logic [1:0] FDIV_RST  = 2'h1;

    // Duty codes; 4 to 7 are reserved
    localparam logic [2:0] DUTY_STATIC  = 3'h0;
    localparam logic [2:0] DUTY_HALF    = 3'h1;
    localparam logic [2:0] DUTY_THIRD   = 3'h2;
    localparam logic [2:0] DUTY_QUARTER = 3'h3;

    // Display memory shape
    localparam int DM_DEPTH = 32;
    localparam int DM_BITS  = 4;
    localparam int DM_AW    = 5;

    // Slow oscillator to base clock division
    localparam int         SLOW_DIV = 64;
    localparam int         PRE_W    = 6;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : sld_pkg

//--- verilog/sld_dm_if.sv
/*
 * Carrier between the control logic and the display memory.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface sld_dm_if;
    logic        wr_en;
    logic [4:0]  wr_idx;
    logic [3:0]  wr_data;
    logic        rd_en;
    logic [4:0]  rd_idx;
    logic [3:0]  rd_data;
    logic [1:0]  com_sel;
    logic [31:0] seg_col;

    modport ctl (output wr_en, wr_idx, wr_data, rd_en, rd_idx, com_sel,
                 input rd_data, seg_col);
    modport mem (input wr_en, wr_idx, wr_data, rd_en, rd_idx, com_sel,
                 output rd_data, seg_col);
endinterface : sld_dm_if

//--- verilog/sld_dmem.sv
/*
 * Display memory: 32 words of 4 bits, a registered read port for the bus
 * and a registered column of one common's bits across all segments.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
module sld_dmem
    import sld_pkg::*;
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Memory side of the carrier
    sld_dm_if.mem     dm
);
    typedef struct packed {
        logic [DM_DEPTH-1:0][DM_BITS-1:0] mem;
        logic [DM_BITS-1:0]               rd_data;
        logic [DM_DEPTH-1:0]              col;
    } sld_dm_st_t;

    sld_dm_st_t q;
    sld_dm_st_t d;

    // Storage, read port and column selection
    always_comb begin
        d = q;
        // [R9] full read back
        if (dm.rd_en) begin
            d.rd_data = q.mem[dm.rd_idx];
        end
        // [R10] spare bits stored
        if (dm.wr_en) begin
            d.mem[dm.wr_idx] = dm.wr_data;
        end
        // [R7] byte n feeds segment n
        for (int n = 0; n < DM_DEPTH; n++) begin
            d.col[n] = q.mem[n][dm.com_sel];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dm.rd_data = q.rd_data;
    assign dm.seg_col = q.col;
endmodule : sld_dmem

//--- verilog/sld_frame_duty.sv
/*
 * Segment LCD frame timing, drive duty scan and display memory access
 * over AXI4-Lite, with the frame interrupt.
 * Assumes slow_osc_tick is a one-cycle pulse per slow oscillator period,
 * synchronous to aclk, and that the panel driver consumes com/seg levels.
 */
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps

// Contract
// [R1] Frame from base clock by divider ratio
// [R2] Ratios 4/8/12/16, third duty 6/9/12/15
// [R3] Frame pin driven only when routed
// [R4] Duty select picks active commons, reset quarter
// [R5] All 32 segment outputs always active
// [R6] 32-byte display memory, software readable/writable
// [R7] Byte n drives segment n, bit k common
// [R8] One lights segment, zero leaves dark
// [R9] Every stored bit reads back
// [R10] Unmapped low bits are plain storage
// [R11] Upper four bits read as zero
// [R12] Base clock is slow oscillator over 64
// [R13] Frame flag every frame, irq when enabled
// [R14] Commons scanned in ascending order
// [R15] Divider restarts when duty or ratio change
module sld_frame_duty
    import sld_pkg::*;
(
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI4-Lite write address
    input  wire logic [SLD_AW-1:0]   awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    // AXI4-Lite write data
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    // AXI4-Lite write response
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    // AXI4-Lite read address
    input  wire logic [SLD_AW-1:0]   araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    // AXI4-Lite read data
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    // Slow oscillator pulse
    input  wire logic                slow_osc_tick,
    // Panel electrodes
    output logic [3:0]               com_drive,
    output logic [DM_DEPTH-1:0]      seg_drive,
    output logic                     frame_sig,
    // Frame output pin
    output logic                     frame_out_pin,
    output logic                     frame_out_pin_oe,
    // Interrupt
    output logic                     irq
);
    import sld_pkg::*;

    typedef struct packed {
        logic              aw_got;
        logic [SLD_IW-1:0] aw_idx;
        logic              w_got;
        logic [7:0]        wbyte;
        logic              wlane;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rd_pend;
        logic [SLD_IW-1:0] rd_idx;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [2:0]        duty;
        logic [1:0]        fdiv;
        logic              route;
        logic              flg;
        logic              msk;
        logic [PRE_W-1:0]  pre_cnt;
        logic [4:0]        slot_cnt;
        logic [1:0]        com;
        logic [3:0]        pos;
        logic              frame;
        logic              frame_pin;
        logic [3:0]        com_drive;
        logic              irq;
    } sld_st_t;

    sld_st_t q;
    sld_st_t d;

    logic              base_tick;
    logic              frame_ev;
    logic              do_wr;
    logic              wr_hit;
    logic [SLD_IW-1:0] ar_idx;
    logic [2:0]        new_duty;
    logic [1:0]        new_fdiv;
    logic [4:0]        slot;
    logic [2:0]        ncom;

    sld_dm_if dm ();

    // Number of active commons for a duty code
    // Reserved codes 4 to 7 fall back to four commons
    function automatic logic [2:0] num_com(input logic [2:0] duty);
        logic [2:0] n;
        n = 3'h4;
        if (duty == DUTY_STATIC) begin
            n = 3'h1;
        end else if (duty == DUTY_HALF) begin
            n = 3'h2;
        end else if (duty == DUTY_THIRD) begin
            n = 3'h3;
        end
        return n;
    endfunction : num_com

    // Base clock ticks per common slot
    function automatic logic [4:0] slot_len(input logic [2:0] duty,
                                            input logic [1:0] sel);
        logic [4:0] s;
        s = 5'({3'h0, sel} + 5'h1);
        if (duty == DUTY_STATIC) begin
            s = 5'(s << 2);
        end else if (duty == DUTY_HALF) begin
            s = 5'(s << 1);
        end else if (duty == DUTY_THIRD) begin
            s = 5'({3'h0, sel} + 5'h2);
        end
        return s;
    endfunction : slot_len

    // Base clock ticks per frame
    function automatic logic [4:0] frame_ratio(input logic [2:0] duty,
                                               input logic [1:0] sel);
        return 5'(slot_len(duty, sel) * 5'(num_com(duty)));
    endfunction : frame_ratio

    // Index falls inside the display memory
    function automatic logic is_dmem(input logic [SLD_IW-1:0] idx);
        return (idx >= IDX_DMEM_BASE) && (idx <= IDX_DMEM_LAST);
    endfunction : is_dmem

    // Index names any register of the block
    function automatic logic is_mapped(input logic [SLD_IW-1:0] idx);
        return is_dmem(idx) || (idx == IDX_CTRL) || (idx == IDX_IMSK)
            || (idx == IDX_IFLG) || (idx == IDX_PFSEL);
    endfunction : is_mapped

    // Bus handshakes
    // Ready stays low while a response waits: one write, one read in flight
    assign awready = !q.aw_got && !q.bvalid;
    assign wready  = !q.w_got && !q.bvalid;
    assign arready = !q.rd_pend && !q.rvalid;
    assign ar_idx  = araddr[SLD_AW-1:2];

    // Memory port: bus reads and writes, column by current common
    // [R6] window decode to word index
    assign dm.rd_en   = arvalid && arready && is_dmem(ar_idx);
    assign dm.rd_idx  = DM_AW'(ar_idx - IDX_DMEM_BASE);
    assign dm.wr_en   = do_wr && q.wlane && is_dmem(q.aw_idx);
    assign dm.wr_idx  = DM_AW'(q.aw_idx - IDX_DMEM_BASE);
    assign dm.wr_data = q.wbyte[DM_BITS-1:0];
    assign dm.com_sel = q.com;

    sld_dmem u_dmem (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dm      (dm.mem)
    );

    // Next state of the whole block
    always_comb begin
        d = q;
        base_tick = 1'b0;
        frame_ev = 1'b0;
        do_wr = q.aw_got && q.w_got && !q.bvalid;
        wr_hit = do_wr && q.wlane;
        new_duty = q.wbyte[DUTY_LSB +: 3];
        new_fdiv = q.wbyte[FDIV_LSB +: 2];
        slot = slot_len(q.duty, q.fdiv);
        ncom = num_com(q.duty);

        // Write address and data, in either order
        if (awvalid && awready) begin
            d.aw_got = 1'b1;
            d.aw_idx = awaddr[SLD_AW-1:2];
        end
        if (wvalid && wready) begin
            d.w_got = 1'b1;
            d.wbyte = wdata[7:0];
            d.wlane = wstrb[0];
        end
        if (do_wr) begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = is_mapped(q.aw_idx) ? RESP_OKAY : RESP_DECERR;
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end

        // Read request, then registered data two cycles later
        // Memory word is taken from the memory's own read register
        if (arvalid && arready) begin
            d.rd_pend = 1'b1;
            d.rd_idx  = ar_idx;
        end
        if (q.rd_pend) begin
            d.rd_pend = 1'b0;
            d.rvalid  = 1'b1;
            d.rresp   = is_mapped(q.rd_idx) ? RESP_OKAY : RESP_DECERR;
            d.rdata   = 32'h0;
            // [R11] high nibble reads zero
            if (is_dmem(q.rd_idx)) begin
                d.rdata[DM_BITS-1:0] = dm.rd_data;
            end else if (q.rd_idx == IDX_CTRL) begin
                d.rdata[DUTY_LSB +: 3] = q.duty;
                d.rdata[FDIV_LSB +: 2] = q.fdiv;
            end else if (q.rd_idx == IDX_IMSK) begin
                d.rdata[0] = q.msk;
            end else if (q.rd_idx == IDX_IFLG) begin
                d.rdata[0] = q.flg;
            end else if (q.rd_idx == IDX_PFSEL) begin
                d.rdata[0] = q.route;
            end
        end
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end

        // [R12] slow oscillator over 64
        // Prescaler is not cleared by control writes
        if (slow_osc_tick) begin
            if (q.pre_cnt == PRE_W'(SLOW_DIV - 1)) begin
                d.pre_cnt = '0;
                base_tick = 1'b1;
            end else begin
                d.pre_cnt = PRE_W'(q.pre_cnt + 1'b1);
            end
        end

        // [R14] ascending common scan
        if (base_tick) begin
            if (q.slot_cnt >= 5'(slot - 5'h1)) begin
                d.slot_cnt = '0;
                // [R1] frame ends after ratio ticks
                if ({1'b0, q.com} >= 3'(ncom - 3'h1)) begin
                    d.com    = '0;
                    frame_ev = 1'b1;
                end else begin
                    d.com = 2'(q.com + 1'b1);
                end
            end else begin
                d.slot_cnt = 5'(q.slot_cnt + 1'b1);
            end
            d.pos = frame_ev ? 4'h0 : 4'(q.pos + 1'b1);
        end

        // Register writes
        if (wr_hit && q.aw_idx == IDX_CTRL) begin
            // [R4] duty select stored
            d.duty = new_duty;
            // [R2] ratio select stored
            d.fdiv = new_fdiv;
            // [R15] restart on change
            if (new_duty != q.duty || new_fdiv != q.fdiv) begin
                d.slot_cnt = '0;
                d.com      = '0;
                d.pos      = '0;
            end
        end
        if (wr_hit && q.aw_idx == IDX_IMSK) begin
            d.msk = q.wbyte[0];
        end
        if (wr_hit && q.aw_idx == IDX_PFSEL) begin
            d.route = q.wbyte[0];
        end

        // [R13] flag set wins over clear
        // A written zero leaves the flag alone
        d.flg = q.flg;
        if (wr_hit && q.aw_idx == IDX_IFLG && q.wbyte[0]) begin
            d.flg = 1'b0;
        end
        if (frame_ev) begin
            d.flg = 1'b1;
        end
        // [R13] request only when enabled
        d.irq = q.flg && q.msk;

        // [R2] frame high for first half
        // Level lags the tick position by one cycle
        d.frame = {1'b0, q.pos} < 5'(frame_ratio(q.duty, q.fdiv) >> 1);
        // [R3] pin follows frame when routed
        d.frame_pin = q.route && q.frame;
        // Common drive aligned with the registered segment column
        d.com_drive = 4'(4'h1 << q.com);
    end

    // State register with synchronous reset
    // Duty and ratio select leave reset at their defaults
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q      <= '0;
            q.duty <= DUTY_RST;
            q.fdiv <= FDIV_RST;
        end else begin
            q <= d;
        end
    end

    // Bus outputs
    assign bresp  = q.bresp;
    assign bvalid = q.bvalid;
    assign rdata  = q.rdata;
    assign rresp  = q.rresp;
    assign rvalid = q.rvalid;

    // Panel outputs
    // Column and common come from one index, so they stay aligned
    assign com_drive = q.com_drive;
    // [R5] all segments always driven
    // [R8] one lights the segment
    assign seg_drive = dm.seg_col;
    assign frame_sig = q.frame;

    // [R3] pin enable from routing bit
    assign frame_out_pin    = q.frame_pin;
    assign frame_out_pin_oe = q.route;

    // Interrupt output
    assign irq = q.irq;
endmodule : sld_frame_duty

//--- verif/sld_frame_duty_properties.sv
/* Checker of the frame block's top ports.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
module sld_frame_duty_chk (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus handshakes
    input wire logic        awready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    // Panel and pin
    input wire logic [3:0]  com_drive,
    input wire logic        frame_sig,
    input wire logic        frame_out_pin,
    input wire logic        frame_out_pin_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Read request taken, then answer two cycles on
    sequence s_ar;
        arvalid && arready;
    endsequence
    sequence s_rans;
        !rvalid ##1 rvalid;
    endsequence
    com_onehot_a: assert property ($past(aresetn) |-> $onehot(com_drive))
        else $error("common drive not one-hot");
    com_order_a: assert property ($past(aresetn) && $changed(com_drive) |->
        com_drive == 4'h1 || com_drive == ($past(com_drive) << 1))
        else $error("commons out of order");
    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    aw_refuse_a: assert property (bvalid |-> !awready)
        else $error("address taken during response");
    read_lat_a: assert property (s_ar |=> s_rans)
        else $error("read answer late");
    pin_off_a: assert property (!frame_out_pin_oe && !$past(frame_out_pin_oe) |-> !frame_out_pin)
        else $error("pin driven while unrouted");
    pin_follow_a: assert property (frame_out_pin_oe && $past(frame_out_pin_oe) |->
        frame_out_pin == $past(frame_sig))
        else $error("pin does not follow frame");
endmodule : sld_frame_duty_chk
bind sld_frame_duty sld_frame_duty_chk u_chk (.aclk, .aresetn, .awready, .bvalid, .bready, .bresp,
    .arvalid, .arready, .rvalid, .rready, .rdata, .com_drive, .frame_sig, .frame_out_pin, .frame_out_pin_oe);

//--- verif/sld_panel_model.sv
/* Panel model: keeps the segment levels seen under each common.
   Assumes one-hot commons and logic-level segments. */
`timescale 1ns/10ps
module sld_panel_model (
    // Clock
    input wire logic        aclk,
    // Electrodes
    input wire logic [3:0]  com_drive,
    input wire logic [31:0] seg_drive,
    // Lit image, one word per common
    output logic [3:0][31:0] lit_q
);
    // latch segments of the active common
    always_ff @(posedge aclk) begin
        for (int k = 0; k < 4; k++) begin
            if (com_drive[k]) lit_q[k] <= seg_drive;
        end
    end
endmodule : sld_panel_model

//--- verif/sld_frame_duty_tb.sv
/* Testbench of the frame, duty and display memory block.
   Assumes an AXI4-Lite master here and the panel model on the electrodes. */
`timescale 1ns/10ps
module sld_frame_duty_tb;
    import sld_pkg::*;
    logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow_osc_tick;
    logic              awready, wready, bvalid, arready, rvalid, frame_sig, frame_out_pin, frame_out_pin_oe, irq;
    logic [SLD_AW-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata, seg_drive, rd_v;
    logic [3:0]        wstrb, com_drive;
    logic [1:0]        bresp, rresp, rsp;
    logic [3:0][31:0]  lit;
    int                n_errors, cmp_count, cyc;
    localparam logic [19:0] A_CTL = {IDX_CTRL, 2'h0};
    localparam logic [19:0] A_MSK = {IDX_IMSK, 2'h0};
    localparam logic [19:0] A_FLG = {IDX_IFLG, 2'h0};

    sld_frame_duty uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .slow_osc_tick, .com_drive, .seg_drive, .frame_sig, .frame_out_pin, .frame_out_pin_oe, .irq);
    sld_panel_model panel (.aclk, .com_drive, .seg_drive, .lit_q(lit));

    // Clock and a slow tick on every second cycle
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) slow_osc_tick <= aresetn && !slow_osc_tick;

    function automatic logic [3:0] mw(input int n);
        return 4'(n * 7 + 3);
    endfunction : mw

    task automatic test_done;
        $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        int i;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (i = 0; i < 50 && bvalid !== 1'b1; i++) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        rsp = bresp;
        bready <= 1'b0;
        if (i == 50) n_errors++;
        if (i == 50) test_done;
    endtask : wr

    task automatic rd(input logic [19:0] a);
        int i;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (i = 0; i < 50 && rvalid !== 1'b1; i++) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        rd_v = rdata;
        rsp  = rresp;
        rready <= 1'b0;
        if (i == 50) n_errors++;
        if (i == 50) test_done;
    endtask : rd

    // Cycles up to the next rise of the frame signal
    task automatic wait_rise;
        int   i;
        logic p;
        p   = frame_sig;
        cyc = 0;
        for (i = 0; i < 3000 && !(frame_sig === 1'b1 && p === 1'b0); i++) begin
            p = frame_sig;
            @(posedge aclk);
            cyc++;
        end
        if (i == 3000) n_errors++;
        if (i == 3000) test_done;
    endtask : wait_rise

    task automatic t_reset;
        repeat (2) @(posedge aclk);
        chk({28'h0, com_drive}, 32'h1);
        rd(A_CTL);
        chk(rd_v, (32'(FDIV_RST) << FDIV_LSB) | 32'(DUTY_RST));
        chk({30'h0, rsp}, 32'(RESP_OKAY));
    endtask : t_reset

    task automatic t_mem;
        for (int n = 0; n < DM_DEPTH; n++) wr({IDX_DMEM_BASE + 18'(n), 2'h0}, {24'hffffff, 4'h9, mw(n)});
        chk({30'h0, rsp}, 32'(RESP_OKAY));
        for (int n = 0; n < DM_DEPTH; n++) begin
            rd({IDX_DMEM_BASE + 18'(n), 2'h0});
            chk(rd_v, {28'h0, mw(n)});
        end
        wr(20'h00010, 32'h1);
        chk({30'h0, rsp}, 32'(RESP_DECERR));
        rd(20'h00010);
        chk(rd_v, 32'h0);
        chk({30'h0, rsp}, 32'(RESP_DECERR));
    endtask : t_mem

    task automatic t_segs;
        logic [31:0] e;
        wait_rise;
        wait_rise;
        for (int k = 0; k < 4; k++) begin
            for (int n = 0; n < DM_DEPTH; n++) e[n] = 1'(mw(n) >> k);
            chk(lit[k], e);
        end
    endtask : t_segs

    task automatic t_irq;
        wr(A_FLG, 32'h1);
        wait_rise;
        rd(A_FLG);
        chk(rd_v, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(A_MSK, 32'h1);
        @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(A_FLG, 32'h1);
        @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
    endtask : t_irq

    task automatic t_pin;
        wr({IDX_PFSEL, 2'h0}, 32'h1);
        wait_rise;
        @(posedge aclk);
        chk({30'h0, frame_out_pin_oe, frame_out_pin}, 32'h3);
        wr({IDX_PFSEL, 2'h0}, 32'h0);
        repeat (2) @(posedge aclk);
        chk({30'h0, frame_out_pin_oe, frame_out_pin}, 32'h0);
    endtask : t_pin

    // Every defined duty code and reserved code 4, with every ratio select
    task automatic t_frames;
        for (int d = 0; d < 5; d++) begin
            for (int s = 0; s < 4; s++) begin
                wr(A_CTL, 32'(d) | (32'(s) << FDIV_LSB));
                rd(A_CTL);
                chk(rd_v, 32'(d) | (32'(s) << FDIV_LSB));
                wait_rise;
                wait_rise;
                chk(32'(cyc), 32'((d == 2 ? 3 * (s + 2) : 4 * (s + 1)) * SLOW_DIV * 2));
            end
        end
    endtask : t_frames

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb     = 4'hf;
        n_errors  = 0;
        cmp_count = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_mem;
        t_segs;
        t_irq;
        t_pin;
        t_frames;
        test_done;
    end
endmodule : sld_frame_duty_tb
